// file: logic/self_test_params.svh
`ifndef SELF_TEST_PARAMS_SVH
`define SELF_TEST_PARAMS_SVH

// register map of the plain software port (byte offsets)
`define ST_ADDR_CONTROL 8'h00
`define ST_ADDR_STATUS 8'h04
`define ST_ADDR_RESULT 8'h08
`define ST_ADDR_CONFIG 8'h0C

// control register fields
`define ST_SELECT_MSB 3
`define ST_LOCK_BIT 4

// status register fields
`define ST_RUNNING_BIT 0
`define ST_FAIL_BIT 1
`define ST_UV_BIT 2

// config register fields
`define ST_POLARITY_BIT 0
`define ST_EVENT_BIT 1

// test codes
`define ST_CODE_NONE 4'h0
`define ST_CODE_CM_DEFAULT 4'h8
`define ST_CODE_DIG_1 4'hC
`define ST_CODE_DIG_2 4'hD
`define ST_CODE_DIG_3 4'hE
`define ST_CODE_DIG_4 4'hF
`define ST_CODE_FIX_0 4'h4
`define ST_CODE_FIX_1 4'h5
`define ST_CODE_FIX_2 4'h6
`define ST_CODE_FIX_3 4'h7

// upper two select bits give the class of a test code
`define ST_CLASS_LSB 2
`define ST_CLASS_DIGITAL 2'b11
`define ST_CLASS_FIXED 2'b01

// forced result words
`define ST_DIGITAL_1 16'h8171
`define ST_DIGITAL_2 16'h6C95
`define ST_DIGITAL_3 16'h807A
`define ST_DIGITAL_4 16'h78AC
`define ST_FIXED_0 16'h0000
`define ST_FIXED_1 16'hAAAA
`define ST_FIXED_2 16'h5555
`define ST_FIXED_3 16'hFFFF

// timing
`define ST_CLOCK_HZ 10000000
`define ST_MOD_RATE_HZ 1000000
`define ST_MOD_DIV (`ST_CLOCK_HZ / `ST_MOD_RATE_HZ)
`define ST_REPEAT_US 1000
`define ST_REPEAT_CYCLES ((`ST_REPEAT_US * (`ST_CLOCK_HZ / 1000000)))

`endif

// file: logic/self_test_pkg.sv
package self_test_pkg;
   typedef enum logic [1:0] {
      MODE_NONE = 2'b00,
      MODE_CM = 2'b01,
      MODE_DIGITAL = 2'b10,
      MODE_FIXED = 2'b11
   } test_mode_t;

   typedef enum logic [1:0] {
      CM_IDLE = 2'b00,
      CM_RUN = 2'b01,
      CM_FINAL = 2'b10
   } cm_state_t;
endpackage

// file: logic/sample_tick.sv
`timescale 1ns/1ps
`include "self_test_params.svh"

// divides the system clock down to the modulator sample rate
module sample_tick #(
   parameter int DIV = `ST_MOD_DIV
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   output logic tick_out
);
   logic [15:0] count;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count <= 16'h0000;
      end else if (count == 16'(DIV - 1)) begin
         count <= 16'h0000;
      end else begin
         count <= count + 16'h0001;
      end
   end

   assign tick_out = (count == 16'(DIV - 1));
endmodule

// file: logic/self_test_control.sv
`timescale 1ns/1ps
`include "self_test_params.svh"

module self_test_control #(
   parameter logic [3:0] CM_CODE = `ST_CODE_CM_DEFAULT,
   parameter int REPEAT_CYCLES = `ST_REPEAT_CYCLES,
   parameter int MOD_DIV = `ST_MOD_DIV
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [7:0] address_in,
   input wire logic [31:0] write_data_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [31:0] read_data_out,
   input wire logic [15:0] dsp_word_in,
   input wire logic dsp_valid_in,
   input wire logic cm_over_limit_in,
   input wire logic cm_done_in,
   input wire logic undervoltage_in,
   input wire logic select_low_in,
   input wire logic modulator_bit_in,
   output logic cm_start_out,
   output logic sample_tick_out,
   output logic sample_bit_out,
   output logic serial_select_out,
   output logic serial_abort_out,
   output logic [3:0] test_select_out,
   output logic [15:0] sensor_result_word_out,
   output logic test_running_flag_out,
   output logic test_fail_flag_out,
   output logic event_output_out
);
   self_test_pkg::test_mode_t mode;
   self_test_pkg::cm_state_t cm_state;
   logic [3:0] test_select;
   logic init_done_lock;
   logic test_running_flag;
   logic test_fail_flag;
   logic polarity_high;
   logic event_request;
   logic [31:0] repeat_count;
   logic [15:0] forced_word;
   logic tick;
   logic cm_selected;
   logic [31:0] next_read_data;

   function automatic self_test_pkg::test_mode_t decode_mode(input logic [3:0] code);
      if (code == CM_CODE) begin
         decode_mode = self_test_pkg::MODE_CM;
      end else if (code[`ST_SELECT_MSB:`ST_CLASS_LSB] == `ST_CLASS_DIGITAL) begin
         decode_mode = self_test_pkg::MODE_DIGITAL;
      end else if (code[`ST_SELECT_MSB:`ST_CLASS_LSB] == `ST_CLASS_FIXED) begin
         decode_mode = self_test_pkg::MODE_FIXED;
      end else begin
         decode_mode = self_test_pkg::MODE_NONE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sample rate

   sample_tick #(
      .DIV(MOD_DIV)
   ) u_tick (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .tick_out(tick)
   );

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sample_bit_out <= 1'b0;
      end else if (tick) begin
         sample_bit_out <= modulator_bit_in;
      end
   end

   assign sample_tick_out = tick;

   ////////////////////////////////////////////////////////////////////////
   // serial port select and undervoltage

   assign serial_select_out = !select_low_in && !undervoltage_in;
   assign serial_abort_out = undervoltage_in;

   ////////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         test_select <= `ST_CODE_NONE;
         init_done_lock <= 1'b0;
      end else if (init_done_lock) begin
         test_select <= `ST_CODE_NONE;
      end else if (write_in && !undervoltage_in && address_in == `ST_ADDR_CONTROL) begin
         init_done_lock <= write_data_in[`ST_LOCK_BIT];
         test_select <= write_data_in[`ST_LOCK_BIT] ? `ST_CODE_NONE : write_data_in[`ST_SELECT_MSB:0];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         polarity_high <= 1'b0;
         event_request <= 1'b0;
      end else if (write_in && !undervoltage_in && address_in == `ST_ADDR_CONFIG) begin
         polarity_high <= write_data_in[`ST_POLARITY_BIT];
         event_request <= write_data_in[`ST_EVENT_BIT];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         event_output_out <= 1'b1;
      end else begin
         event_output_out <= event_request ~^ polarity_high;
      end
   end

   assign mode = decode_mode(test_select);
   assign cm_selected = (mode == self_test_pkg::MODE_CM);

   ////////////////////////////////////////////////////////////////////////
   // common-mode test sequencing

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         repeat_count <= 32'h00000000;
      end else if (cm_state == self_test_pkg::CM_IDLE || repeat_count == 32'(REPEAT_CYCLES - 1)) begin
         repeat_count <= 32'h00000000;
      end else begin
         repeat_count <= repeat_count + 32'h00000001;
      end
   end

   // start pulse at selection and each period
   assign cm_start_out = (cm_state == self_test_pkg::CM_IDLE && cm_selected) ||
                         (cm_state == self_test_pkg::CM_RUN && cm_selected &&
                          repeat_count == 32'(REPEAT_CYCLES - 1));

   // final result within one period of deselect
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cm_state <= self_test_pkg::CM_IDLE;
      end else begin
         case (cm_state)
            self_test_pkg::CM_IDLE: begin
               if (cm_selected) begin
                  cm_state <= self_test_pkg::CM_RUN;
               end
            end
            self_test_pkg::CM_RUN: begin
               if (!cm_selected) begin
                  cm_state <= self_test_pkg::CM_FINAL;
               end
            end
            self_test_pkg::CM_FINAL: begin
               if (cm_done_in || repeat_count == 32'(REPEAT_CYCLES - 1)) begin
                  cm_state <= self_test_pkg::CM_IDLE;
               end
            end
            default: begin
               cm_state <= self_test_pkg::CM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         test_fail_flag <= 1'b0;
      end else if (cm_state != self_test_pkg::CM_IDLE && cm_done_in && cm_over_limit_in) begin
         test_fail_flag <= 1'b1;
      end else if (cm_state == self_test_pkg::CM_IDLE && cm_selected) begin
         test_fail_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         test_running_flag <= 1'b0;
      end else begin
         test_running_flag <= (mode != self_test_pkg::MODE_NONE) ||
                              (cm_state == self_test_pkg::CM_RUN) ||
                              (cm_state == self_test_pkg::CM_FINAL && !cm_done_in &&
                               repeat_count != 32'(REPEAT_CYCLES - 1));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result word

   always_comb begin
      case (test_select)
         `ST_CODE_DIG_1: forced_word = `ST_DIGITAL_1;
         `ST_CODE_DIG_2: forced_word = `ST_DIGITAL_2;
         `ST_CODE_DIG_3: forced_word = `ST_DIGITAL_3;
         `ST_CODE_DIG_4: forced_word = `ST_DIGITAL_4;
         `ST_CODE_FIX_0: forced_word = `ST_FIXED_0;
         `ST_CODE_FIX_1: forced_word = `ST_FIXED_1;
         `ST_CODE_FIX_2: forced_word = `ST_FIXED_2;
         `ST_CODE_FIX_3: forced_word = `ST_FIXED_3;
         default: forced_word = `ST_FIXED_0;
      endcase
   end

   // normal updates return on next sample
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sensor_result_word_out <= 16'h0000;
      end else if (mode == self_test_pkg::MODE_FIXED) begin
         sensor_result_word_out <= forced_word;
      end else if (mode == self_test_pkg::MODE_DIGITAL) begin
         if (dsp_valid_in) begin
            sensor_result_word_out <= forced_word;
         end
      end else if (dsp_valid_in) begin
         sensor_result_word_out <= dsp_word_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read port

   always_comb begin
      next_read_data = 32'h00000000;
      case (address_in)
         `ST_ADDR_CONTROL: begin
            next_read_data[`ST_SELECT_MSB:0] = test_select;
            next_read_data[`ST_LOCK_BIT] = init_done_lock;
         end
         `ST_ADDR_STATUS: begin
            next_read_data[`ST_RUNNING_BIT] = test_running_flag;
            next_read_data[`ST_FAIL_BIT] = test_fail_flag;
            next_read_data[`ST_UV_BIT] = undervoltage_in;
         end
         `ST_ADDR_RESULT: next_read_data[15:0] = sensor_result_word_out;
         `ST_ADDR_CONFIG: begin
            next_read_data[`ST_POLARITY_BIT] = polarity_high;
            next_read_data[`ST_EVENT_BIT] = event_request;
         end
         default: next_read_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         read_data_out <= 32'h00000000;
      end else if (read_in && !undervoltage_in) begin
         read_data_out <= next_read_data;
      end else begin
         read_data_out <= 32'h00000000;
      end
   end

   assign test_select_out = test_select;
   assign test_running_flag_out = test_running_flag;
   assign test_fail_flag_out = test_fail_flag;

   ////////////////////////////////////////////////////////////////////////
   // checks

   chk_lock_clears_select: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      init_done_lock |=> test_select == `ST_CODE_NONE) else $error("select not cleared under lock");
   chk_lock_sticks: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      init_done_lock |=> init_done_lock) else $error("lock released without reset");
   chk_cm_start_state: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cm_state == self_test_pkg::CM_IDLE && cm_selected) |=> test_running_flag && !test_fail_flag)
      else $error("cm start flags wrong");
   chk_fail_on_limit: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cm_state != self_test_pkg::CM_IDLE && cm_done_in && cm_over_limit_in) |=> test_fail_flag)
      else $error("fail flag missed");
   chk_final_bounded: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      repeat_count <= 32'(REPEAT_CYCLES - 1)) else $error("repeat timer overran period");
   chk_running_final: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cm_state == self_test_pkg::CM_FINAL) |-> test_running_flag)
      else $error("running dropped before final result");
   chk_digital_word: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (test_select == `ST_CODE_DIG_1 && dsp_valid_in) |=> sensor_result_word_out == `ST_DIGITAL_1)
      else $error("digital word wrong");
   chk_fixed_word: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (test_select == `ST_CODE_FIX_1 && $stable(test_select)) |=> sensor_result_word_out == `ST_FIXED_1)
      else $error("fixed word wrong");
   chk_tick_rate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      tick |=> !tick [*2]) else $error("sample ticks too close");
endmodule

// file: sim/sense_env_model.sv
`timescale 1ns/1ps

// stands in for the modulator, filter output and common-mode measurement
module sense_env_model #(
   parameter int SAMPLE_GAP = 10,
   parameter int CM_LATENCY = 3,
   parameter logic [15:0] WORD = 16'h1234
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic cm_start_in,
   input wire logic fail_mode_in,
   output logic [15:0] dsp_word_out,
   output logic dsp_valid_out,
   output logic cm_done_out,
   output logic cm_over_limit_out,
   output logic modulator_bit_out
);
   int gap_count;
   int cm_count;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap_count <= 0;
         dsp_valid_out <= 1'b0;
         modulator_bit_out <= 1'b0;
      end else begin
         modulator_bit_out <= ~modulator_bit_out;
         dsp_valid_out <= (gap_count == SAMPLE_GAP - 1);
         gap_count <= (gap_count == SAMPLE_GAP - 1) ? 0 : gap_count + 1;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cm_count <= 0;
      end else if (cm_start_in) begin
         cm_count <= CM_LATENCY;
      end else if (cm_count > 0) begin
         cm_count <= cm_count - 1;
      end
   end

   // outside a valid sample the lines show the inverse, never a held value
   assign dsp_word_out = dsp_valid_out ? WORD : ~WORD;
   assign cm_done_out = (cm_count == 1);
   assign cm_over_limit_out = cm_done_out ? fail_mode_in : ~fail_mode_in;
endmodule

// file: sim/pressure_sensor_self_test_control_tb_top.sv
`timescale 1ns/1ps
`include "self_test_params.svh"
`define CMP(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
$display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module pressure_sensor_self_test_control_tb_top;
   localparam logic [15:0] ENV_WORD = 16'h1234;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] address = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic uv = 1'b0;
   logic sel_low = 1'b1;
   logic fail_mode = 1'b0;
   logic [31:0] rdata;
   logic [15:0] dsp_word, result;
   logic dsp_valid, cm_over, cm_done, mod_bit, cm_start, tick, sbit, ssel, sabort, running, fail, evt;
   logic [3:0] tsel;
   int err_total = 0;
   int checked = 0;

   initial begin
      forever #50 clock_in = ~clock_in;
   end

   self_test_control #(.REPEAT_CYCLES(20)) u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .address_in(address), .write_data_in(wdata), .write_in(wr), .read_in(rd), .read_data_out(rdata),
      .dsp_word_in(dsp_word), .dsp_valid_in(dsp_valid), .cm_over_limit_in(cm_over), .cm_done_in(cm_done),
      .undervoltage_in(uv), .select_low_in(sel_low), .modulator_bit_in(mod_bit), .cm_start_out(cm_start),
      .sample_tick_out(tick), .sample_bit_out(sbit), .serial_select_out(ssel), .serial_abort_out(sabort),
      .test_select_out(tsel), .sensor_result_word_out(result), .test_running_flag_out(running),
      .test_fail_flag_out(fail), .event_output_out(evt));

   sense_env_model #(.WORD(ENV_WORD)) u_env (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .cm_start_in(cm_start), .fail_mode_in(fail_mode), .dsp_word_out(dsp_word), .dsp_valid_out(dsp_valid),
      .cm_done_out(cm_done), .cm_over_limit_out(cm_over), .modulator_bit_out(mod_bit));

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic limit_hit(input int i, input int lim);
      if (i >= lim) begin
         err_total++;
         $display("BAD t=%0t wait ran out", $time);
         results();
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      address <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_in);
      address <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_idle_and_polarity();
      logic [31:0] d;
      `CMP(tsel, 4'h0)
      reg_rd(`ST_ADDR_STATUS, d);
      `CMP(d[2:0], 3'h0)
      for (int v = 0; v < 4; v++) begin
         reg_wr(`ST_ADDR_CONFIG, 32'(v));
         cycles(1);
         `CMP(evt, ~(v[0] ^ v[1]))
      end
      reg_wr(`ST_ADDR_CONFIG, 32'h0);
   endtask

   task automatic t_forced(input logic [3:0] base, input logic [15:0] exp [4]);
      logic [31:0] d;
      for (int k = 0; k < 4; k++) begin
         reg_wr(`ST_ADDR_CONTROL, 32'(base) + 32'(k));
         `CMP(tsel, base + 4'(k))
         // covers at least one filter sample, which must not get through
         cycles(12);
         `CMP(result, exp[k])
         `CMP(running, 1'b1)
         reg_rd(`ST_ADDR_RESULT, d);
         `CMP(d[15:0], exp[k])
      end
   endtask

   task automatic t_normal();
      logic [3:0] codes [2] = '{4'h0, 4'h1};
      for (int k = 0; k < 2; k++) begin
         reg_wr(`ST_ADDR_CONTROL, 32'(codes[k]));
         cycles(12);
         `CMP(result, ENV_WORD)
         `CMP(running, 1'b0)
      end
   endtask

   task automatic t_common_mode(input logic bad);
      int i;
      int n = 0;
      fail_mode <= bad;
      reg_wr(`ST_ADDR_CONTROL, 32'h8);
      cycles(2);
      `CMP(running, 1'b1)
      `CMP(fail, 1'b0)
      for (i = 0; i < 50 && fail !== bad; i++) cycles(1);
      limit_hit(i, 50);
      // a second period must pass with one more start and the verdict unchanged
      for (i = 0; i < 25; i++) begin
         cycles(1);
         n += (cm_start === 1'b1);
      end
      `CMP(n, 1)
      `CMP(fail, bad)
      reg_wr(`ST_ADDR_CONTROL, 32'h0);
      `CMP(running, 1'b1)
      for (i = 0; i < 30 && running !== 1'b0; i++) cycles(1);
      limit_hit(i, 30);
      `CMP(fail, bad)
   endtask

   task automatic t_undervoltage();
      logic [31:0] d;
      @(posedge clock_in);
      sel_low <= 1'b0;
      uv <= 1'b1;
      #1;
      `CMP(sabort, 1'b1)
      `CMP(ssel, 1'b0)
      reg_wr(`ST_ADDR_CONTROL, 32'h4);
      `CMP(tsel, 4'h0)
      reg_rd(`ST_ADDR_STATUS, d);
      `CMP(d, 32'h0)
      @(posedge clock_in);
      uv <= 1'b0;
      #1;
      `CMP(ssel, 1'b1)
      `CMP(sabort, 1'b0)
      reg_rd(`ST_ADDR_RESULT, d);
      `CMP(d[15:0], ENV_WORD)
      @(posedge clock_in);
      sel_low <= 1'b1;
      #1;
      `CMP(ssel, 1'b0)
   endtask

   task automatic t_tick_rate();
      int n = 0;
      logic m = 1'b0;
      logic pend = 1'b0;
      for (int i = 0; i < 100; i++) begin
         cycles(1);
         // the bit seen beside a tick must be the one captured at the next edge
         if (pend) `CMP(sbit, m)
         pend = (tick === 1'b1);
         m = mod_bit;
         n += (tick === 1'b1);
      end
      `CMP(n, 10)
   endtask

   task automatic t_lock();
      logic [31:0] d;
      reg_wr(`ST_ADDR_CONTROL, 32'h5);
      `CMP(tsel, 4'h5)
      reg_wr(`ST_ADDR_CONTROL, 32'h10);
      `CMP(tsel, 4'h0)
      reg_rd(`ST_ADDR_CONTROL, d);
      `CMP(d[4:0], 5'h10)
      reg_wr(`ST_ADDR_CONTROL, 32'hC);
      `CMP(tsel, 4'h0)
      reg_wr(`ST_ADDR_CONTROL, 32'h6);
      cycles(2);
      `CMP(tsel, 4'h0)
      `CMP(running, 1'b0)
      @(posedge clock_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      reset_n_in <= 1'b1;
      #1;
      reg_wr(`ST_ADDR_CONTROL, 32'h4);
      `CMP(tsel, 4'h4)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] fixed [4] = '{`ST_FIXED_0, `ST_FIXED_1, `ST_FIXED_2, `ST_FIXED_3};
      logic [15:0] digital [4] = '{`ST_DIGITAL_1, `ST_DIGITAL_2, `ST_DIGITAL_3, `ST_DIGITAL_4};
      repeat (12) @(posedge clock_in);
      reset_n_in <= 1'b1;
      cycles(1);
      t_idle_and_polarity();
      t_forced(4'h4, fixed);
      // host waits for the chain to settle before comparing
      t_forced(4'hC, digital);
      t_normal();
      t_common_mode(1'b1);
      t_common_mode(1'b0);
      t_undervoltage();
      t_tick_rate();
      t_lock();
      results();
   end
endmodule
